/* File: core/dprc_regs.sv */
// Dual-port receive control registers with lock, back-channel and equalizer controls
//
// Functional notes
// - Lock mode 0: lock only with active video
// - Lock mode 1: lock whenever linked to serializer
// - Raw back-channel passes local gpio unfiltered
// - Lane mode field selects auto/two/primary/secondary
// - Port-1 select writes port-1 copy plus shared
// - Port-1 select reads port-1 copy plus shared
// - Port-0 select writes port-0 copy plus shared
// - Port-0 select resets to 1, rest 0
// - Port-0 only selected reads port-0 copy
// - Both selected: port-1 copy is read
// - Port-1 select steers equalizer test register
// - Restart bit written high then low
// - Restart request restarts both ports
// - Override bit gates the floor preset
// - Preset floor starts adaptation from floor
`timescale 1ns/1ps
module dprc_regs #(
  parameter int DATA_W = 8  // Register data width
) (
  // Clock and reset
  input  wire  logic              clk,
  input  wire  logic              nrst,
  // Register access from the serial control slave
  input  wire  logic              reg_wr_en,
  input  wire  logic              reg_rd_en,
  input  wire  logic [7:0]        reg_addr,
  input  wire  logic [DATA_W-1:0] reg_wdata,
  output logic       [DATA_W-1:0] reg_rdata,
  // Link status from the receiver
  input  wire  logic              link_linked,
  input  wire  logic              fwd_video_disabled,
  output logic                    rx_lock,
  // Secondary back channel
  input  wire  logic              local_gpio_zero,
  input  wire  logic              filtered_gpio_zero,
  output logic                    remote_gpio_zero,
  // Receive lane selection
  output logic       [1:0]        receive_lane_mode,
  // Equalizer controls, index 0 = port 0, index 1 = port 1
  output logic       [1:0]        eq_hold_init,
  output logic       [1:0]        eq_start_floor
);

  // Width check: the register map is byte wide
  if (DATA_W != 8) begin : g_bad_width
    $error("dprc_regs: DATA_W must be 8");
  end

  // Register state
  logic [DATA_W-1:0] ctl_reg,  ctl_next;   // Shared dual_receive_control
  logic [DATA_W-1:0] eq0_reg,  eq0_next;   // Port-0 equalizer_test_control copy
  logic [DATA_W-1:0] eq1_reg,  eq1_next;   // Port-1 equalizer_test_control copy
  logic [DATA_W-1:0] rd_reg,   rd_next;    // Read data holding register
  // Output flops
  logic              lock_reg,  lock_next;
  logic              gpio_reg,  gpio_next;
  logic [1:0]        lane_reg,  lane_next;
  logic [1:0]        hold_reg,  hold_next;
  logic [1:0]        floor_reg, floor_next;
  // Decoded selects
  logic              p0_sel;               // Port-0 access select
  logic              p1_sel;               // Port-1 access select
  logic              restart_any;          // Restart from either copy

  assign p0_sel = ctl_reg[dprc_pkg::P0_SEL_BIT];
  assign p1_sel = ctl_reg[dprc_pkg::P1_SEL_BIT];

  // Register writes and read mux
  always_comb begin
    ctl_next = ctl_reg;
    eq0_next = eq0_reg;
    eq1_next = eq1_reg;
    rd_next  = rd_reg;
    if (reg_wr_en) begin
      // Shared register written whatever the port select
      if (reg_addr == dprc_pkg::ADDR_DUAL_RECEIVE_CONTROL) begin
        ctl_next = reg_wdata;
        ctl_next[dprc_pkg::RSVD_CTL_BIT] = 1'h0;  // Read-only reserved bit
      end
      // Per-port copies follow the selects
      if (reg_addr == dprc_pkg::ADDR_EQ_TEST) begin
        if (p0_sel) begin
          eq0_next = reg_wdata;
        end
        if (p1_sel) begin
          eq1_next = reg_wdata;
        end
      end
    end
    if (reg_rd_en) begin
      unique case (reg_addr)
        dprc_pkg::ADDR_DUAL_RECEIVE_CONTROL: begin
          rd_next = ctl_reg;
        end
        dprc_pkg::ADDR_EQ_TEST: begin
          // Port 1 wins when both are selected
          rd_next = p1_sel ? eq1_reg : eq0_reg;
        end
        default: begin
          rd_next = dprc_pkg::UNMAPPED_READ;
        end
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_reg <= dprc_pkg::CTL_RESET;
      eq0_reg <= dprc_pkg::EQ_RESET;
      eq1_reg <= dprc_pkg::EQ_RESET;
      rd_reg  <= dprc_pkg::UNMAPPED_READ;
    end else begin
      ctl_reg <= ctl_next;
      eq0_reg <= eq0_next;
      eq1_reg <= eq1_next;
      rd_reg  <= rd_next;
    end
  end

  assign restart_any = eq0_reg[dprc_pkg::EQ_RESTART_BIT] | eq1_reg[dprc_pkg::EQ_RESTART_BIT];

  // Control outputs derived from the registers
  always_comb begin
    // Lock indication depends on the lock mode
    if (ctl_reg[dprc_pkg::LOCK_MODE_BIT]) begin
      lock_next = link_linked;
    end else begin
      lock_next = link_linked & ~fwd_video_disabled;
    end
    // Raw mode bypasses the oversampling filter
    if (ctl_reg[dprc_pkg::RAW_BC_BIT]) begin
      gpio_next = local_gpio_zero;
    end else begin
      gpio_next = filtered_gpio_zero;
    end
    lane_next  = ctl_reg[dprc_pkg::LANE_HI_BIT:dprc_pkg::LANE_LO_BIT];
    // Either copy restarts both ports, held while high
    hold_next  = {2{restart_any}};
    // Preset floor counts only under override
    floor_next[0] = eq0_reg[dprc_pkg::EQ_OVERRIDE_BIT] & eq0_reg[dprc_pkg::EQ_PRESET_BIT];
    floor_next[1] = eq1_reg[dprc_pkg::EQ_OVERRIDE_BIT] & eq1_reg[dprc_pkg::EQ_PRESET_BIT];
  end

  // Output flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_reg  <= 1'h0;
      gpio_reg  <= 1'h0;
      lane_reg  <= dprc_pkg::LANE_AUTO;
      hold_reg  <= 2'h0;
      floor_reg <= 2'h0;
    end else begin
      lock_reg  <= lock_next;
      gpio_reg  <= gpio_next;
      lane_reg  <= lane_next;
      hold_reg  <= hold_next;
      floor_reg <= floor_next;
    end
  end

  assign reg_rdata         = rd_reg;
  assign rx_lock           = lock_reg;
  assign remote_gpio_zero  = gpio_reg;
  assign receive_lane_mode = lane_reg;
  assign eq_hold_init      = hold_reg;
  assign eq_start_floor    = floor_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_write_eq;
    reg_wr_en && reg_addr == dprc_pkg::ADDR_EQ_TEST;
  endsequence

  sequence s_restart_seen;
    eq0_reg[dprc_pkg::EQ_RESTART_BIT] || eq1_reg[dprc_pkg::EQ_RESTART_BIT];
  endsequence

  // Write to the shared control register
  sequence s_write_ctl;
    reg_wr_en && reg_addr == dprc_pkg::ADDR_DUAL_RECEIVE_CONTROL;
  endsequence

  // Read of the per-port equalizer register
  sequence s_read_eq;
    reg_rd_en && reg_addr == dprc_pkg::ADDR_EQ_TEST;
  endsequence

  // Restart released in both copies
  sequence s_restart_clear;
    !eq0_reg[dprc_pkg::EQ_RESTART_BIT] && !eq1_reg[dprc_pkg::EQ_RESTART_BIT];
  endsequence

  // Restart written high, then written low
  sequence s_restart_pulse;
    s_restart_seen ##1 s_restart_clear;
  endsequence

  chk_lock_video_mode: assert property (
    !ctl_reg[dprc_pkg::LOCK_MODE_BIT] |=> rx_lock == ($past(link_linked) && !$past(fwd_video_disabled)))
    else $error("lock in video mode wrong");

  chk_lock_link_mode: assert property (
    ctl_reg[dprc_pkg::LOCK_MODE_BIT] && link_linked |=> rx_lock)
    else $error("lock in link mode missing");

  chk_raw_backchannel: assert property (
    ctl_reg[dprc_pkg::RAW_BC_BIT] |=> remote_gpio_zero == $past(local_gpio_zero))
    else $error("raw back channel not passed");

  chk_lane_mode_out: assert property (
    ##1 receive_lane_mode == $past(ctl_reg[dprc_pkg::LANE_HI_BIT:dprc_pkg::LANE_LO_BIT]))
    else $error("lane mode output mismatch");

  chk_port1_write: assert property (
    s_write_eq and p1_sel |=> eq1_reg == $past(reg_wdata))
    else $error("port-1 copy not written");

  chk_port0_write: assert property (
    s_write_eq and p0_sel |=> eq0_reg == $past(reg_wdata))
    else $error("port-0 copy not written");

  chk_port_read_mux: assert property (
    reg_rd_en && reg_addr == dprc_pkg::ADDR_EQ_TEST |=> reg_rdata == ($past(p1_sel) ? $past(eq1_reg) : $past(eq0_reg)))
    else $error("read steering wrong");

  chk_reset_values: assert property (
    $past(!nrst) |-> ctl_reg == dprc_pkg::CTL_RESET)
    else $error("control reset value wrong");

  chk_restart_both: assert property (
    s_restart_seen |=> eq_hold_init == 2'h3)
    else $error("restart not on both ports");

  chk_floor_gate: assert property (
    !eq0_reg[dprc_pkg::EQ_OVERRIDE_BIT] |=> !eq_start_floor[0])
    else $error("floor preset not gated");

  // Shared register, read data and equalizer reset checks
  chk_ctl_write: assert property (
    s_write_ctl |=> ctl_reg[dprc_pkg::RSVD_CTL_BIT-1:0] == $past(reg_wdata[dprc_pkg::RSVD_CTL_BIT-1:0]))
    else $error("control register not written");

  chk_reserved_zero: assert property (
    !ctl_reg[dprc_pkg::RSVD_CTL_BIT])
    else $error("reserved control bit set");

  chk_ctl_read: assert property (
    reg_rd_en && reg_addr == dprc_pkg::ADDR_DUAL_RECEIVE_CONTROL |=> reg_rdata == $past(ctl_reg))
    else $error("control register read wrong");

  chk_rdata_hold: assert property (
    !reg_rd_en |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  chk_eq_reset: assert property (
    $past(!nrst) |-> eq0_reg == dprc_pkg::EQ_RESET && eq1_reg == dprc_pkg::EQ_RESET)
    else $error("equalizer reset value wrong");

  // Port steering checks
  chk_read_port0: assert property (
    s_read_eq and (p0_sel && !p1_sel) |=> reg_rdata == $past(eq0_reg))
    else $error("port-0 copy not read");

  chk_read_port1: assert property (
    s_read_eq and p1_sel |=> reg_rdata == $past(eq1_reg))
    else $error("port-1 copy not read first");

  chk_port0_isolated: assert property (
    s_write_eq and !p0_sel |=> $stable(eq0_reg))
    else $error("port-0 copy written while unselected");

  chk_port1_isolated: assert property (
    s_write_eq and !p1_sel |=> $stable(eq1_reg))
    else $error("port-1 copy written while unselected");

  // Link status and back-channel checks
  chk_lock_no_link: assert property (
    !link_linked |=> !rx_lock)
    else $error("lock without link");

  chk_gpio_filtered: assert property (
    !ctl_reg[dprc_pkg::RAW_BC_BIT] |=> remote_gpio_zero == $past(filtered_gpio_zero))
    else $error("filtered back channel not passed");

  // Equalizer control checks
  chk_restart_pulse: assert property (
    s_restart_pulse |-> eq_hold_init == 2'h3 ##1 eq_hold_init == 2'h0)
    else $error("restart pulse not followed");

  chk_restart_release: assert property (
    s_restart_clear |=> eq_hold_init == 2'h0)
    else $error("adaptation held after restart release");

  chk_floor_gate_p1: assert property (
    !eq1_reg[dprc_pkg::EQ_OVERRIDE_BIT] |=> !eq_start_floor[1])
    else $error("port-1 floor preset not gated");

  chk_floor_preset_p0: assert property (
    eq0_reg[dprc_pkg::EQ_OVERRIDE_BIT] && eq0_reg[dprc_pkg::EQ_PRESET_BIT] |=> eq_start_floor[0])
    else $error("port-0 floor preset missing");

  chk_floor_preset_p1: assert property (
    eq1_reg[dprc_pkg::EQ_OVERRIDE_BIT] && eq1_reg[dprc_pkg::EQ_PRESET_BIT] |=> eq_start_floor[1])
    else $error("port-1 floor preset missing");

endmodule : dprc_regs

/* File: core/dprc_pkg.sv */
// Constants shared by the dual-port receive control register slice
package dprc_pkg;
  // Register offsets on the serial control bus
  localparam logic [7:0] ADDR_DUAL_RECEIVE_CONTROL = 8'h34;
  localparam logic [7:0] ADDR_EQ_TEST     = 8'h35;
  // Field positions in dual_receive_control
  localparam int LOCK_MODE_BIT = 6;
  localparam int RAW_BC_BIT    = 5;
  localparam int LANE_HI_BIT   = 4;
  localparam int LANE_LO_BIT   = 3;
  localparam int RSVD_CTL_BIT  = 7;
  localparam int P1_SEL_BIT    = 1;
  localparam int P0_SEL_BIT    = 0;
  // Field positions in equalizer_test_control
  localparam int EQ_RESTART_BIT  = 6;
  localparam int EQ_OVERRIDE_BIT = 5;
  localparam int EQ_PRESET_BIT   = 4;
  // Reset values
  localparam logic [7:0] CTL_RESET     = 8'h01;
  localparam logic [7:0] EQ_RESET      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Lane mode codes
  localparam logic [1:0] LANE_AUTO     = 2'h0;
  localparam logic [1:0] LANE_TWO      = 2'h1;
  localparam logic [1:0] LANE_ONE_PRI  = 2'h2;
  localparam logic [1:0] LANE_ONE_SEC  = 2'h3;
endpackage : dprc_pkg

/* File: sim/dprc_host.sv */
// Register host model driving the strobe bus of the slice
`timescale 1ns/1ps
module dprc_host (
  // Clock
  input  wire  logic       clk,
  // Strobe bus toward the slice
  output logic             reg_wr_en,
  output logic             reg_rd_en,
  output logic [7:0]       reg_addr,
  output logic [7:0]       reg_wdata,
  // Read data from the slice
  input  wire  logic [7:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    {reg_wr_en, reg_rd_en} = 2'h0;
    {reg_addr, reg_wdata}  = 16'h0000;
  end
  // One strobe cycle; read data taken at the next falling edge, as the bus is scrambled
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    {reg_addr, reg_wdata}  = {a, d};
    {reg_wr_en, reg_rd_en} = {wr, ~wr};
    @(negedge clk);
    {reg_wr_en, reg_rd_en} = 2'h0;
    {reg_addr, reg_wdata}  = ~{a, d};
    q = reg_rdata;
  endtask : xfer
endmodule : dprc_host

/* File: sim/tb_top.sv */
// Self-checking bench for the dual-port receive control slice
`timescale 1ns/1ps
module tb_top;
  logic        clk, nrst, reg_wr_en, reg_rd_en;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rb;
  logic        link_linked, fwd_video_disabled, rx_lock, local_gpio_zero, filtered_gpio_zero, remote_gpio_zero;
  logic [1:0]  receive_lane_mode, eq_hold_init, eq_start_floor;
  logic [15:0] lq;
  int          miscompares = 0;
  int          samples_checked = 0;
  // Device and host model
  dprc_regs u_dut (.clk, .nrst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .link_linked,
    .fwd_video_disabled, .rx_lock, .local_gpio_zero, .filtered_gpio_zero, .remote_gpio_zero,
    .receive_lane_mode, .eq_hold_init, .eq_start_floor);
  dprc_host u_host (.clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata);
  // 100 ns clock
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Next random state
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Expected lock level
  function automatic logic exp_lock(input logic lock_mode, input logic linked, input logic vid_off);
    return linked & (lock_mode | ~vid_off);
  endfunction : exp_lock
  // Expected back-channel level
  function automatic logic exp_gpio(input logic raw, input logic local_lvl, input logic filt_lvl);
    return raw ? local_lvl : filt_lvl;
  endfunction : exp_gpio
  // Expected {hold, floor} from both equalizer copies
  function automatic logic [3:0] exp_eq(input logic [7:0] e0, input logic [7:0] e1);
    return {{2{e0[dprc_pkg::EQ_RESTART_BIT] | e1[dprc_pkg::EQ_RESTART_BIT]}},
            e1[dprc_pkg::EQ_OVERRIDE_BIT] & e1[dprc_pkg::EQ_PRESET_BIT],
            e0[dprc_pkg::EQ_OVERRIDE_BIT] & e0[dprc_pkg::EQ_PRESET_BIT]};
  endfunction : exp_eq
  // Byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    miscompares += int'(got !== exp);
    if (got !== exp) $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
  endtask : chk
  // Register write and read-compare
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.xfer(1'h1, a, d, rb);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    u_host.xfer(1'h0, a, 8'h00, rb);
    chk(rb, exp);
  endtask : rdc
  // Counts, verdict, end of run
  task automatic stop_test;
    $display("checked=%0d mismatched=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // Main sequence
  initial begin
    nrst = 1'h0;
    {link_linked, fwd_video_disabled, local_gpio_zero, filtered_gpio_zero} = 4'h0;
    lq = 16'h9354;
    repeat (8) @(negedge clk);
    nrst = 1'h1;
    rdc(8'h34, 8'h01);
    rdc(8'h35, 8'h00);
    rdc(8'h36, 8'h00);
    // Outputs idle after reset with all inputs low
    chk({rx_lock, remote_gpio_zero, receive_lane_mode, eq_hold_init, eq_start_floor}, 8'h00);
    $display("reset test done");
    // Lane codes, lock modes, back channel; top bit of 0x34 read-only
    for (int m = 0; m < 4; m++) begin
      wr(8'h34, {1'h1, m[1:0], m[1:0], 3'h1});
      rdc(8'h34, {1'h0, m[1:0], m[1:0], 3'h1});
      chk({6'h0, receive_lane_mode}, {6'h0, m[1:0]});
      repeat (8) begin
        lq = lfsr(lq);
        {link_linked, fwd_video_disabled, local_gpio_zero, filtered_gpio_zero} = lq[3:0];
        repeat (2) @(negedge clk);
        chk({7'h0, rx_lock}, {7'h0, exp_lock(m[1], link_linked, fwd_video_disabled)});
        chk({7'h0, remote_gpio_zero}, {7'h0, exp_gpio(m[0], local_gpio_zero, filtered_gpio_zero)});
      end
    end
    $display("link test done");
    // Random equalizer bytes, both ports selected
    wr(8'h34, 8'h03);
    repeat (8) begin
      lq = lfsr(lq);
      wr(8'h35, lq[7:0]);
      rdc(8'h35, lq[7:0]);
      chk({4'h0, eq_hold_init, eq_start_floor}, {4'h0, exp_eq(lq[7:0], lq[7:0])});
    end
    $display("equalizer test done");
    // Per-port copies and steering
    wr(8'h35, 8'h10);
    wr(8'h34, 8'h01);
    wr(8'h35, 8'h30);
    wr(8'h34, 8'h02);
    wr(8'h35, 8'h40);
    @(negedge clk);
    chk({4'h0, eq_hold_init, eq_start_floor}, 8'h0D);
    rdc(8'h35, 8'h40);
    wr(8'h34, 8'h03);
    rdc(8'h35, 8'h40);
    wr(8'h34, 8'h01);
    rdc(8'h35, 8'h30);
    wr(8'h34, 8'h02);
    wr(8'h35, 8'h00);
    @(negedge clk);
    chk({6'h0, eq_hold_init}, 8'h00);
    $display("steering test done");
    // Mid-run reset must restore defaults over written values
    nrst = 1'h0;
    {link_linked, fwd_video_disabled, local_gpio_zero, filtered_gpio_zero} = 4'h0;
    repeat (2) @(negedge clk);
    nrst = 1'h1;
    rdc(8'h34, 8'h01);
    rdc(8'h35, 8'h00);
    chk({rx_lock, remote_gpio_zero, receive_lane_mode, eq_hold_init, eq_start_floor}, 8'h00);
    $display("mid-run reset test done");
    stop_test();
  end
endmodule : tb_top
